// [rsp_pkg.sv]
// Constants and types of the radio serial register port.
// Assumes a single 50 MHz clock and plain-port configuration.
package rsp_pkg;
  localparam int CLK_MHZ         = 50;
  localparam int SLEEP_MAX_US    = 35;
  localparam int SLEEP_MAX_CYC   = SLEEP_MAX_US * CLK_MHZ;
  localparam int FAST_SETTLE_US  = 100;
  localparam int SLOW_SETTLE_US  = 250;
  localparam int OSC_RESTART_US  = 1000;
  localparam int CNT_W           = 20;

  // Command byte fields
  localparam int CMD_DIR_BIT     = 7;
  localparam int CMD_INC_BIT     = 6;
  localparam int ADDR_W          = 6;

  // Register addresses
  localparam logic [5:0] A_CHAN  = 6'h00;
  localparam logic [5:0] A_MODE  = 6'h01;
  localparam logic [5:0] A_XACT  = 6'h02;
  localparam logic [5:0] A_IRQC  = 6'h03;
  localparam logic [5:0] A_IEN   = 6'h04;
  localparam logic [5:0] A_STAT  = 6'h05;
  localparam logic [5:0] A_CLKO  = 6'h06;
  localparam logic [5:0] A_LVD   = 6'h07;
  localparam logic [5:0] A_BUF   = 6'h08;
  localparam logic [5:0] A_PWR   = 6'h09;

  // Transaction config fields
  localparam int XACT_FRC_BIT    = 5;
  localparam int XACT_AUTO_BIT   = 0;
  localparam logic [2:0] END_SLEEP = 3'h0;

  // Mode commands
  localparam logic [1:0] MODE_TX = 2'h1;
  localparam logic [1:0] MODE_RX = 2'h2;

  // Status bits
  localparam int ST_TX  = 0;
  localparam int ST_RX  = 1;
  localparam int ST_OSC = 2;
  localparam int ST_LV  = 3;
  localparam int ST_W   = 4;

  localparam logic [6:0] FAST_CH_MAX  = 7'h48;
  localparam logic [6:0] FAST_CH_STEP = 7'h03;
  localparam logic [2:0] LV_THR_NUM   = 3'h7;
  localparam logic [2:0] CLKO_SEL_MAX = 3'h4;
  localparam logic [3:0] CLKO_RESET   = 4'h8;

  typedef struct packed {
    logic three_wire;
    logic irq_on_mosi;
    logic open_drain;
    logic active_high;
  } rsp_irqc_s;

  typedef struct packed {
    logic             dir;
    logic             inc;
    logic [5:0]       addr;
  } rsp_cmd_s;

  typedef enum logic [2:0] {
    PW_IDLE   = 3'b000,
    PW_SLEEP  = 3'b001,
    PW_OSC    = 3'b010,
    PW_SETTLE = 3'b011,
    PW_RUN    = 3'b100
  } rsp_pwr_e;
endpackage

// [rsp_sync3.sv]
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs asynchronous to mclk.
module rsp_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Pins and filtered levels
  input  wire logic [W-1:0] pin,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge mclk) begin
    s1_q <= pin;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // Level moves only when second and third stages agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      level <= rst_val;
    end else begin
      level <= ((s2_q ~^ s3_q) & s2_q) | (~(s2_q ~^ s3_q) & level);
    end
  end
endmodule

// [rsp_clkdiv.sv]
// Clock-out divider of the 12 MHz reference.
// Assumes ref_tick pulses once per reference half period.
module rsp_clkdiv (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Control
  input  wire logic       ref_tick,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  // Output
  output logic            clk_out
);
  import rsp_pkg::*;
  logic [3:0] cnt_q;
  logic [3:0] lim;

  always_comb begin
    lim = 4'h0;
    if (sel <= CLKO_SEL_MAX) begin
      lim = 4'((5'h01 << sel) - 5'h01);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt_q   <= 4'h0;
      clk_out <= 1'b0;
    end else if (ref_tick) begin
      if (cnt_q >= lim) begin
        cnt_q   <= 4'h0;
        clk_out <= ~clk_out;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// [rsp_port.sv]
// Serial register port of the radio with power, interrupt and clock-out.
// Assumes host-driven serial pins and oscillator strobes on mclk.
//
// Function
// - First byte bit 7: one write, zero read
// - Increment bit advances address per data byte
// - Command byte holds six-bit address, then data
// - Burst runs until select returns high
// - Three-wire mode drives shared line only reading
// - Buffer register fills and drains as FIFO
// - Interrupt on data input only while deselected
// - Port works without the internal oscillator
// - Interrupt polarity and drive type programmable
// - Grouped sources share pin, enables persist
// - Status shows conditions even when disabled
// - Clock out divides reference, enabled at reset
// - Force-end write with end-state zero sleeps
// - Optional sleep after packet completion
// - Transmit or receive command wakes, waits oscillator
// - Interrupt when restarted oscillator is stable
// - Low-battery threshold select, readable, may interrupt
// - Low-voltage status live, off while asleep
// - Every third channel to 72 settles fast
module rsp_port
  import rsp_pkg::*;
#(
  parameter int OSC_RESTART_CYC = OSC_RESTART_US * CLK_MHZ,
  parameter int FAST_SETTLE_CYC = FAST_SETTLE_US * CLK_MHZ,
  parameter int SLOW_SETTLE_CYC = SLOW_SETTLE_US * CLK_MHZ,
  parameter int BUF_DEPTH       = 16
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Serial pins
  input  wire logic       ss_n,
  input  wire logic       sck,
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe,
  output logic            miso_o,
  output logic            miso_oe,
  // Interrupt pin
  output logic            irq_o,
  output logic            irq_oe,
  // Radio events and status
  input  wire logic       tx_done,
  input  wire logic       rx_done,
  input  wire logic       ref_tick,
  input  wire logic       vbat_low,
  output logic            osc_en,
  output logic            radio_go,
  output logic [1:0]      radio_mode,
  output logic [6:0]      channel,
  output logic [2:0]      lv_threshold,
  output logic            lv_enable,
  output logic            clk_out
);
  import rsp_pkg::*;

  localparam int BUF_AW = $clog2(BUF_DEPTH);

  logic [3:0]        sync_lvl;
  logic              ss_f;
  logic              sck_f;
  logic              mosi_f;
  logic              lv_f;
  logic              sck_p_q;
  logic              rise;
  logic              fall;
  logic [2:0]        bit_cnt_q;
  logic [6:0]        sh_in_q;
  logic              first_q;
  rsp_cmd_s          cmd_q;
  logic              byte_v;
  logic [7:0]        byte_val;
  logic              wr_en;
  logic              rd_load;
  logic [5:0]        cur_addr;
  logic [7:0]        rd_data;
  logic [7:0]        tx_sh_q;
  logic              rd_q;
  logic              out_q;
  rsp_irqc_s         irqc_q;
  logic [ST_W-1:0]   ien_q;
  logic [ST_W-1:0]   st_q;
  logic [ST_W-1:0]   st_set;
  logic [ST_W-1:0]   st_clr;
  logic [ST_W-1:0]   st_view;
  logic              irq_act;
  logic              irq_lvl;
  logic [3:0]        clko_q;
  logic [5:0]        xact_q;
  logic              sleep_req;
  logic              wake_req;
  rsp_pwr_e          pwr_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              fast_ch;
  logic [CNT_W-1:0]  settle_lim;
  logic              osc_ev;
  logic [7:0]        buf_mem [BUF_DEPTH];
  logic [BUF_AW-1:0] wp_q;
  logic [BUF_AW-1:0] rp_q;
  logic [BUF_AW:0]   fill_q;
  logic              buf_push;
  logic              buf_pop;

  // Pin conditioning
  rsp_sync3 #(
    .W (4)
  ) u_sync (
    .mclk    (mclk),
    .rst     (rst),
    .pin     ({ss_n, sck, mosi_i, vbat_low}),
    .rst_val (4'h8),
    .level   (sync_lvl)
  );

  assign ss_f   = sync_lvl[3];
  assign sck_f  = sync_lvl[2];
  assign mosi_f = sync_lvl[1];
  assign lv_f   = sync_lvl[0];

  // Clocked on mclk only, no dependence on the radio oscillator
  always_ff @(posedge mclk) begin
    if (rst) begin
      sck_p_q <= 1'b0;
    end else begin
      sck_p_q <= sck_f;
    end
  end

  assign rise = sck_f & ~sck_p_q & ~ss_f;
  assign fall = ~sck_f & sck_p_q & ~ss_f;

  // Byte assembly, MSB first on rising edges
  assign byte_val = {sh_in_q, mosi_f};
  assign byte_v   = rise && (bit_cnt_q == 3'h7);

  always_ff @(posedge mclk) begin
    if (rst || ss_f) begin
      bit_cnt_q <= 3'h0;
      sh_in_q   <= 7'h00;
    end else if (rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      sh_in_q   <= byte_val[6:0];
    end
  end

  // Command byte capture and address stepping
  always_ff @(posedge mclk) begin
    if (rst || ss_f) begin
      first_q <= 1'b1;
      rd_q    <= 1'b0;
    end else if (byte_v && first_q) begin
      first_q <= 1'b0;
      rd_q    <= ~byte_val[CMD_DIR_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_q <= '0;
    end else if (byte_v) begin
      cmd_q <= first_q ? rsp_cmd_s'(byte_val) : rsp_cmd_s'({cmd_q.dir, cmd_q.inc, cur_addr});
    end
  end

  // Address of the next data byte, stepped after each one only when the increment bit is set
  always_comb begin
    cur_addr = cmd_q.addr;
    if (first_q) begin
      cur_addr = byte_val[ADDR_W-1:0];
    end else if (cmd_q.inc) begin
      cur_addr = 6'(cmd_q.addr + 6'h01);
    end
  end

  assign wr_en   = byte_v && !first_q && cmd_q.dir;
  assign rd_load = byte_v && (first_q ? !byte_val[CMD_DIR_BIT] : !cmd_q.dir);

  // Write address is the one the byte was aimed at
  logic [5:0] wr_addr;
  assign wr_addr = cmd_q.addr;

  // Read data selection
  always_comb begin
    rd_data = 8'h00;
    unique case (cur_addr)
      A_CHAN:  rd_data = {1'b0, channel};
      A_MODE:  rd_data = {6'h00, radio_mode};
      A_XACT:  rd_data = {2'h0, xact_q};
      A_IRQC:  rd_data = {4'h0, irqc_q};
      A_IEN:   rd_data = {4'h0, ien_q};
      A_STAT:  rd_data = {4'h0, st_view};
      A_CLKO:  rd_data = {4'h0, clko_q};
      A_LVD:   rd_data = {st_view[ST_LV], 4'h0, lv_threshold};
      A_BUF:   rd_data = (fill_q != '0) ? buf_mem[rp_q] : 8'h00;
      A_PWR:   rd_data = {5'h00, pwr_q};
      default: rd_data = 8'h00;
    endcase
  end

  // Read shifter, changes on falling edges
  always_ff @(posedge mclk) begin
    if (rst || ss_f) begin
      tx_sh_q <= 8'h00;
      out_q   <= 1'b0;
    end else if (rd_load) begin
      tx_sh_q <= rd_data;
    end else if (fall) begin
      out_q   <= tx_sh_q[7];
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      channel      <= 7'h00;
      irqc_q       <= '0;
      ien_q        <= '0;
      clko_q       <= CLKO_RESET;
      lv_threshold <= 3'h0;
    end else if (wr_en) begin
      unique case (wr_addr)
        A_CHAN:  channel <= byte_val[6:0];
        A_IRQC:  irqc_q  <= rsp_irqc_s'(byte_val[3:0]);
        A_IEN:   ien_q   <= byte_val[ST_W-1:0];
        A_CLKO:  clko_q  <= byte_val[3:0];
        A_LVD: begin
          if (byte_val[2:0] < LV_THR_NUM) begin
            lv_threshold <= byte_val[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Transaction config; force-end bit self-clears once acted on
  assign sleep_req = (wr_en && wr_addr == A_XACT && byte_val[XACT_FRC_BIT]
                      && byte_val[4:2] == END_SLEEP)
                   || (xact_q[XACT_AUTO_BIT] && (tx_done || rx_done));
  assign wake_req  = wr_en && wr_addr == A_MODE
                   && (byte_val[1:0] == MODE_TX || byte_val[1:0] == MODE_RX);

  always_ff @(posedge mclk) begin
    if (rst) begin
      xact_q <= 6'h00;
    end else if (wr_en && wr_addr == A_XACT) begin
      xact_q <= {1'b0, byte_val[4:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      radio_mode <= 2'h0;
    end else if (sleep_req) begin
      radio_mode <= 2'h0;
    end else if (wr_en && wr_addr == A_MODE) begin
      radio_mode <= byte_val[1:0];
    end
  end

  // Fast channels: multiples of three up to 72
  assign fast_ch    = (channel <= FAST_CH_MAX) && ((channel % FAST_CH_STEP) == 7'h00);
  assign settle_lim = fast_ch ? CNT_W'(FAST_SETTLE_CYC) : CNT_W'(SLOW_SETTLE_CYC);

  // Power sequencing
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr_q <= PW_IDLE;
      cnt_q <= '0;
    end else if (sleep_req) begin
      pwr_q <= PW_SLEEP;
      cnt_q <= '0;
    end else if (wake_req) begin
      pwr_q <= (pwr_q == PW_SLEEP) ? PW_OSC : PW_SETTLE;
      cnt_q <= '0;
    end else begin
      unique case (pwr_q)
        PW_IDLE, PW_SLEEP, PW_RUN: cnt_q <= '0;
        PW_OSC: begin
          if (cnt_q >= CNT_W'(OSC_RESTART_CYC - 1)) begin
            pwr_q <= PW_SETTLE;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PW_SETTLE: begin
          if (cnt_q >= settle_lim - 1'b1) begin
            pwr_q <= PW_RUN;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  assign osc_ev = (pwr_q == PW_OSC) && (cnt_q >= CNT_W'(OSC_RESTART_CYC - 1))
                  && !sleep_req && !wake_req;

  always_ff @(posedge mclk) begin
    if (rst) begin
      osc_en    <= 1'b1;
      radio_go  <= 1'b0;
      lv_enable <= 1'b1;
    end else begin
      osc_en    <= (pwr_q != PW_SLEEP);
      radio_go  <= (pwr_q == PW_RUN) && (radio_mode != 2'h0);
      lv_enable <= (pwr_q != PW_SLEEP);
    end
  end

  // Status: events sticky until read, set beats clear
  assign st_set = {1'b0, osc_ev, rx_done, tx_done};
  assign st_clr = (rd_load && cur_addr == A_STAT) ? {1'b0, {(ST_W-1){1'b1}}} : '0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= (st_q & ~st_clr) | st_set;
    end
  end

  // Low voltage follows comparator, dropped in sleep
  assign st_view = {lv_f & (pwr_q != PW_SLEEP), st_q[ST_OSC:0]};
  assign irq_act = |(st_view & ien_q);
  assign irq_lvl = irqc_q.active_high ? irq_act : ~irq_act;

  // Pin drivers
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_o   <= 1'b1;
      irq_oe  <= 1'b0;
      mosi_o  <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o  <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      irq_o   <= irqc_q.open_drain ? 1'b0 : irq_lvl;
      irq_oe  <= !irqc_q.irq_on_mosi && (!irqc_q.open_drain || !irq_lvl);
      miso_o  <= out_q;
      miso_oe <= !ss_f && rd_q && !irqc_q.three_wire;
      if (ss_f && irqc_q.irq_on_mosi) begin
        mosi_o  <= irqc_q.open_drain ? 1'b0 : irq_lvl;
        mosi_oe <= !irqc_q.open_drain || !irq_lvl;
      end else begin
        mosi_o  <= out_q;
        mosi_oe <= !ss_f && rd_q && irqc_q.three_wire;
      end
    end
  end

  // Buffer register: non-incrementing bursts fill and drain it
  assign buf_push = wr_en && wr_addr == A_BUF && (fill_q != (BUF_AW+1)'(BUF_DEPTH));
  assign buf_pop  = rd_load && cur_addr == A_BUF && (fill_q != '0);

  always_ff @(posedge mclk) begin
    if (buf_push) begin
      buf_mem[wp_q] <= byte_val;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wp_q   <= '0;
      rp_q   <= '0;
      fill_q <= '0;
    end else begin
      if (buf_push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (buf_pop) begin
        rp_q <= rp_q + 1'b1;
      end
      fill_q <= fill_q + (BUF_AW+1)'(buf_push) - (BUF_AW+1)'(buf_pop);
    end
  end

  // Clock out, stopped while the oscillator is off
  rsp_clkdiv u_clkdiv (
    .mclk     (mclk),
    .rst      (rst),
    .ref_tick (ref_tick),
    .run      (clko_q[3] && pwr_q != PW_SLEEP),
    .sel      (clko_q[2:0]),
    .clk_out  (clk_out)
  );
endmodule

// [rsp_port_asserts.sv]
// Port-level checker of the serial register port.
// Assumes rsp_port ports and the synchronous active-high reset.
module rsp_port_asserts #(
  parameter int OSC_RESTART_CYC = 20,
  parameter int FAST_SETTLE_CYC = 10,
  parameter int SLOW_SETTLE_CYC = 30
) (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Serial pins
  input wire logic       ss_n,
  input wire logic       sck,
  input wire logic       mosi_i,
  input wire logic       mosi_o,
  input wire logic       mosi_oe,
  input wire logic       miso_o,
  input wire logic       miso_oe,
  // Interrupt pin
  input wire logic       irq_o,
  input wire logic       irq_oe,
  // Radio side
  input wire logic       tx_done,
  input wire logic       rx_done,
  input wire logic       ref_tick,
  input wire logic       vbat_low,
  input wire logic       osc_en,
  input wire logic       radio_go,
  input wire logic [1:0] radio_mode,
  input wire logic [6:0] channel,
  input wire logic [2:0] lv_threshold,
  input wire logic       lv_enable,
  input wire logic       clk_out
);
  localparam int WAKE_MAX = OSC_RESTART_CYC + SLOW_SETTLE_CYC + FAST_SETTLE_CYC + 16;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  idle_release_a: assert property (ss_n [*6] |-> !miso_oe)
    else $error("miso driven while deselected");
  one_drive_a: assert property (!(miso_oe && mosi_oe))
    else $error("both data pins driven");
  burst_end_a: assert property ($fell(miso_oe) |-> ss_n)
    else $error("read drive ended with select low");
  read_start_a: assert property ($rose(miso_oe) |-> !ss_n)
    else $error("read drive began while deselected");
  sleep_lv_a: assert property (!osc_en [*2] |-> !lv_enable)
    else $error("battery monitor on in sleep");
  go_osc_a: assert property (radio_go |-> osc_en && radio_mode != 2'h0)
    else $error("radio started without oscillator or mode");
  wake_hold_a: assert property ($rose(osc_en) |-> !radio_go [*8])
    else $error("radio started before restart delay");
  wake_bound_a: assert property ($rose(osc_en) |-> ##[1:WAKE_MAX] radio_go)
    else $error("radio not started after wake");
  sleep_clear_a: assert property ($fell(osc_en) |-> radio_mode == 2'h0 && !radio_go)
    else $error("mode kept on sleep entry");
  thr_range_a: assert property (lv_threshold != 3'h7)
    else $error("threshold outside seven choices");

  sleep_c: cover property ($fell(osc_en));
  go_c: cover property ($rose(radio_go));
  irq_c: cover property ($rose(irq_oe));
  read_c: cover property ($rose(miso_oe));
endmodule

bind rsp_port rsp_port_asserts #(
  .OSC_RESTART_CYC(OSC_RESTART_CYC),
  .FAST_SETTLE_CYC(FAST_SETTLE_CYC),
  .SLOW_SETTLE_CYC(SLOW_SETTLE_CYC)
) u_chk (.*);

// [rsp_host_model.sv]
// Host microcontroller model, master of the serial port.
// Assumes mode 0, 8 mclk per serial clock phase, pulled-up data line.
module rsp_host_model (
  // Clock and returned data
  input  wire logic  mclk,
  input  wire logic  sdi,
  // Serial pins
  output logic       ss_n,
  output logic       sck,
  output logic       mosi_d,
  output logic       mosi_en,
  // Read bytes
  output logic [7:0] rx_byte,
  output logic       rx_stb
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ss_n = 1'b1;
    sck = 1'b0;
    mosi_d = 1'b0;
    mosi_en = 1'b0;
    rx_byte = 8'h00;
    rx_stb = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic sel(input logic on);
    tick(1);
    ss_n = !on;
    tick(8);
  endtask

  // Shifts n bits MSB first; data out released while reading
  task automatic put(input logic [7:0] b, input logic rd, input int n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_d = b[i];
      mosi_en = !rd;
      tick(8);
      sck = 1'b1;
      r[i] = sdi;
      tick(8);
      sck = 1'b0;
    end
    mosi_en = 1'b0;
    if (rd) begin
      rx_byte = r;
      rx_stb = 1'b1;
      tick(1);
      rx_stb = 1'b0;
    end
  endtask
endmodule

// [tb_rsp_port.sv]
// Self-checking bench of the serial register port.
// Assumes rsp_port, its checker and the host model.
module tb_rsp_port;
  timeunit 1ns;
  timeprecision 1ps;
  import rsp_pkg::*;

  logic       mclk, rst, tx_done, rx_done, ref_tick, vbat_low, tw;
  logic       mosi_o, mosi_oe, miso_o, miso_oe, irq_o, irq_oe;
  logic       osc_en, radio_go, lv_enable, clk_out, ss_n, sck, h_d, h_en, rx_stb;
  logic [1:0] radio_mode;
  logic [6:0] channel;
  logic [2:0] lv_threshold;
  logic [7:0] rx_byte, exp_q[$];
  int         err_count, comparisons, acc;
  // Shared line idles high through a pull-up
  wire logic  mosi_i = mosi_oe ? mosi_o : (h_en ? h_d : 1'b1);
  wire logic  sdi = tw ? mosi_i : (miso_oe ? miso_o : 1'b1);

  rsp_port #(.OSC_RESTART_CYC(20), .FAST_SETTLE_CYC(10), .SLOW_SETTLE_CYC(30)) u_dut (.*);
  rsp_host_model u_host (.mclk(mclk), .sdi(sdi), .ss_n(ss_n), .sck(sck), .mosi_d(h_d),
    .mosi_en(h_en), .rx_byte(rx_byte), .rx_stb(rx_stb));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Reference strobe at 24 MHz on average
  initial begin
    ref_tick = 1'b0;
    forever begin
      @(posedge mclk);
      #2;
      acc = acc + 24;
      ref_tick = acc >= 50;
      if (acc >= 50) acc = acc - 50;
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    comparisons++;
    if (seen !== expd) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic lim(input int n, input int m);
    if (n >= m) begin
      err_count++;
      $display("[ERR] %0t wait %h limit %h", $time, n, m);
      summarize();
    end
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic wr(input logic [5:0] a, input logic inc, input logic [7:0] d[$]);
    u_host.sel(1'b1);
    u_host.put({1'b1, inc, a}, 1'b0, 8);
    foreach (d[i]) u_host.put(d[i], 1'b0, 8);
    u_host.sel(1'b0);
  endtask

  task automatic rd(input logic [5:0] a, input logic inc, input logic [7:0] e[$]);
    u_host.sel(1'b1);
    u_host.put({1'b0, inc, a}, 1'b0, 8);
    foreach (e[i]) begin
      exp_q.push_back(e[i]);
      u_host.put(8'h00, 1'b1, 8);
    end
    u_host.sel(1'b0);
  endtask

  task automatic pulse(input logic tx);
    @(posedge mclk);
    #2;
    tx_done = tx;
    rx_done = !tx;
    @(posedge mclk);
    #2;
    tx_done = 1'b0;
    rx_done = 1'b0;
    repeat (3) @(posedge mclk);
    #2;
  endtask

  always @(posedge mclk) begin
    if (rx_stb === 1'b1) begin
      if (exp_q.size() > 0) check(rx_byte, exp_q.pop_front());
      else check(rx_byte, 8'hxx);
    end
  end

  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    summarize();
  end

  initial begin
    logic [7:0] s, ch, thr;
    logic       b;
    int         n;
    rst = 1'b1;
    tw = 1'b0;
    tx_done = 1'b0;
    rx_done = 1'b0;
    vbat_low = 1'b0;
    repeat (6) @(posedge mclk);
    #2;
    rst = 1'b0;
    repeat (10) @(posedge mclk);
    #2;
    check({2'h0, irq_oe, miso_oe, mosi_oe, osc_en, radio_go, lv_enable}, 8'h25);
    b = clk_out;
    n = 0;
    while (clk_out === b && n < 20) begin
      @(posedge mclk);
      n++;
    end
    check({7'h0, n < 20}, 8'h01);
    $display("test reset done");
    s = lfsr(8'd51);
    ch = {1'b0, s[6:0]};
    s = lfsr(s);
    thr = {5'h0, s[2:0] % 3'h7};
    wr(A_CHAN, 1'b1, '{ch});
    check({1'b0, channel}, ch);
    wr(A_CLKO, 1'b1, '{8'h08, thr});
    check({5'h0, lv_threshold}, thr);
    rd(A_CLKO, 1'b1, '{8'h08, thr});
    rd(A_CHAN, 1'b0, '{ch, ch});
    u_host.sel(1'b1);
    u_host.put({1'b1, 1'b0, A_CHAN}, 1'b0, 8);
    u_host.put(8'h55, 1'b0, 4);
    u_host.sel(1'b0);
    rd(A_CHAN, 1'b0, '{ch});
    wr(A_BUF, 1'b0, '{ch, thr, 8'ha5});
    rd(A_BUF, 1'b0, '{ch, thr, 8'ha5, 8'h00});
    $display("test access done");
    wr(A_IRQC, 1'b0, '{8'h09});
    tw = 1'b1;
    rd(A_CHAN, 1'b0, '{ch});
    wr(A_IRQC, 1'b0, '{8'h01});
    tw = 1'b0;
    $display("test three wire done");
    wr(A_IEN, 1'b0, '{8'h01});
    pulse(1'b1);
    pulse(1'b0);
    check({6'h0, irq_o, irq_oe}, 8'h03);
    rd(A_STAT, 1'b0, '{8'h03, 8'h00});
    check({6'h0, irq_o, irq_oe}, 8'h01);
    wr(A_IRQC, 1'b0, '{8'h02});
    check({7'h0, irq_oe}, 8'h00);
    pulse(1'b1);
    check({6'h0, irq_o, irq_oe}, 8'h01);
    rd(A_STAT, 1'b0, '{8'h01});
    vbat_low = 1'b1;
    repeat (8) @(posedge mclk);
    rd(A_LVD, 1'b0, '{8'h80 | thr});
    vbat_low = 1'b0;
    repeat (8) @(posedge mclk);
    rd(A_LVD, 1'b0, '{thr});
    $display("test interrupt done");
    wr(A_XACT, 1'b0, '{8'h20});
    n = 0;
    while (osc_en !== 1'b0 && n < SLEEP_MAX_CYC) begin
      @(posedge mclk);
      n++;
    end
    lim(n, SLEEP_MAX_CYC);
    check({6'h0, osc_en, lv_enable}, 8'h00);
    rd(A_CHAN, 1'b0, '{ch});
    wr(A_IEN, 1'b0, '{8'h04});
    wr(A_MODE, 1'b0, '{{6'h0, MODE_TX}});
    n = 0;
    while (radio_go !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    lim(n, 200);
    check({4'h0, radio_mode, irq_o, irq_oe}, {4'h0, MODE_TX, 2'b01});
    rd(A_STAT, 1'b0, '{8'h04});
    check({7'h0, exp_q.size() == 0}, 8'h01);
    $display("test sleep done");
    summarize();
  end
endmodule
